// ### design/tte_engine.sv
`timescale 1ns/1ps
// Transport timer, retry and duplicate detection engine
module tte_engine #(
   parameter int unsigned TICK_CYCLES = tte_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Configuration
   input wire logic [tte_pkg::CNT_W-1:0] fbw_n,
   input wire logic [tte_pkg::TMR_W-1:0] nongrp_rx_ms,
   // Send request
   input wire logic tx_req_valid,
   input wire tte_pkg::tte_txreq_t tx_req,
   output logic tx_busy,
   // Buffer availability
   input wire logic buf_free,
   // Transmission strobe
   output logic xmit_valid,
   output logic xmit_retry,
   output logic [tte_pkg::MEMBERS-1:0] xmit_ack_mask,
   // Acknowledgements from peers
   input wire logic ack_valid,
   input wire logic [tte_pkg::MEM_W-1:0] ack_member,
   // Send outcome
   output logic tx_done,
   output logic tx_fail,
   output logic fatal_reset,
   // Arriving packets
   input wire logic rx_valid,
   input wire tte_pkg::tte_rxpkt_t rx_pkt,
   // Receive outcome
   output logic rx_accept,
   output logic rx_dup,
   output logic rx_drop,
   output logic rx_send_ack
);

   //-------------------------------------------------------------------
   // Declarations
   //-------------------------------------------------------------------
   localparam int unsigned D = tte_pkg::RXT_DEPTH;

   logic core_nrst;
   logic ms_tick, sec_tick;

   tte_pkg::tte_state_t st_q, st_d;
   tte_pkg::tte_txreq_t req_q, req_d;
   logic [tte_pkg::MEMBERS-1:0] mask_q, mask_d, mask_new;
   logic [tte_pkg::CNT_W-1:0] retry_q, retry_d, rpt_q, rpt_d;
   logic att_q, att_d;
   logic busy_d, xv_d, xr_d, done_d, fail_d, fatal_d;
   logic [tte_pkg::MEMBERS-1:0] xm_d;

   logic fbw_on_q, fbw_on_d, fbw_go, fbw_exp;
   logic [tte_pkg::SEC_W-1:0] fbw_sec_q, fbw_sec_d, fbw_lim;

   logic xt_load, xt_stop, xt_exp;
   logic rt_load, rt_stop, rt_exp;

   logic [D-1:0] val_q, val_d, live, hit, alloc, rx_exp;
   logic [tte_pkg::SRC_W-1:0] src_q [D];
   logic [tte_pkg::SRC_W-1:0] src_d [D];
   logic [tte_pkg::TID_W-1:0] tid_q [D];
   logic [tte_pkg::TID_W-1:0] tid_d [D];
   logic [tte_pkg::TMR_W-1:0] rx_ms;
   logic [tte_pkg::RXT_IW:0] slot;
   logic acc_d, dup_d, drop_d, rack_d;

   //-------------------------------------------------------------------
   // Functions
   //-------------------------------------------------------------------
   // Members expected to acknowledge, low bits up to the member count
   function automatic logic [tte_pkg::MEMBERS-1:0] want_mask(input logic [tte_pkg::MEM_W:0] n);
      logic [tte_pkg::MEMBERS-1:0] m;
      m = tte_pkg::MASK_RST;
      for (int i = 0; i < tte_pkg::MEMBERS; i++) begin
         m[i] = (7'(i) < n);
      end
      return m;
   endfunction

   // Lowest free slot, top bit set when one is found
   function automatic logic [tte_pkg::RXT_IW:0] first_free(input logic [D-1:0] used);
      logic [tte_pkg::RXT_IW:0] r;
      r = '0;
      for (int i = D - 1; i >= 0; i--) begin
         if (!used[i]) begin
            r = {1'b1, tte_pkg::RXT_IW'(i)};
         end
      end
      return r;
   endfunction

   //-------------------------------------------------------------------
   // Time base and self reset
   //-------------------------------------------------------------------
   // A fatal buffer wait clears the whole engine for one cycle
   assign core_nrst = nrst & ~fatal_reset;

   tte_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clock(clock),
      .nrst(core_nrst),
      .ms_tick(ms_tick),
      .sec_tick(sec_tick)
   );

   // Separate counters so a repeat never disturbs a transaction wait
   tte_cnt u_xact (
      .clock(clock),
      .nrst(core_nrst),
      .load(xt_load),
      .load_ms(req_q.xact_ms),
      .stop(xt_stop),
      .tick(ms_tick),
      .running(),
      .expire(xt_exp)
   );

   tte_cnt u_rpt (
      .clock(clock),
      .nrst(core_nrst),
      .load(rt_load),
      .load_ms(req_q.rpt_ms),
      .stop(rt_stop),
      .tick(ms_tick),
      .running(),
      .expire(rt_exp)
   );

   //-------------------------------------------------------------------
   // Free-buffer wait, counted in whole seconds
   //-------------------------------------------------------------------
   // The second tick runs free, so the first one lands within a second
   // of the start; one extra tick keeps the wait inside its window.
   assign fbw_lim = (tte_pkg::SEC_W'(1) << fbw_n) + tte_pkg::SEC_W'(1);
   assign fbw_exp = fbw_on_q && (fbw_sec_q >= fbw_lim) && (st_q == tte_pkg::ST_WAIT_BUF);

   always_comb begin
      fbw_on_d = fbw_on_q;
      fbw_sec_d = fbw_sec_q;
      if (fbw_go) begin
         fbw_on_d = (fbw_n != tte_pkg::CNT_RST);
         fbw_sec_d = tte_pkg::SEC_RST;
      end else if (fbw_on_q && sec_tick && !fbw_exp) begin
         fbw_sec_d = fbw_sec_q + tte_pkg::SEC_W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (!core_nrst) begin
         fbw_on_q <= 1'b0;
         fbw_sec_q <= tte_pkg::SEC_RST;
      end else begin
         fbw_on_q <= fbw_on_d;
         fbw_sec_q <= fbw_sec_d;
      end
   end

   //-------------------------------------------------------------------
   // Send sequencer
   //-------------------------------------------------------------------
   assign mask_new = mask_q | (tte_pkg::MASK_RST | (64'h1 << ack_member));

   always_comb begin
      st_d = st_q;
      req_d = req_q;
      mask_d = mask_q;
      retry_d = retry_q;
      rpt_d = rpt_q;
      att_d = att_q;
      xv_d = 1'b0;
      xr_d = 1'b0;
      xm_d = xmit_ack_mask;
      done_d = 1'b0;
      fail_d = 1'b0;
      fatal_d = 1'b0;
      fbw_go = 1'b0;
      xt_load = 1'b0;
      xt_stop = 1'b0;
      rt_load = 1'b0;
      rt_stop = 1'b0;
      case (st_q)
         tte_pkg::ST_IDLE: begin
            if (tx_req_valid) begin
               req_d = tx_req;
               mask_d = tte_pkg::MASK_RST;
               retry_d = tx_req.retry;
               // Count of total transmissions; zero is taken as one
               rpt_d = (tx_req.rpt_cnt == tte_pkg::CNT_RST) ? tte_pkg::CNT_RST :
                       tx_req.rpt_cnt - 4'h1;
               att_d = 1'b0;
               fbw_go = 1'b1;
               st_d = tte_pkg::ST_WAIT_BUF;
            end
         end
         tte_pkg::ST_WAIT_BUF: begin
            if (buf_free) begin
               xv_d = 1'b1;
               xr_d = att_q;
               xm_d = mask_q;
               case (req_q.svc)
                  tte_pkg::SVC_ACK: begin
                     xt_load = 1'b1;
                     st_d = tte_pkg::ST_WAIT_ACK;
                  end
                  tte_pkg::SVC_REPEAT: begin
                     rt_load = 1'b1;
                     st_d = tte_pkg::ST_WAIT_RPT;
                  end
                  default: begin
                     // Sent once; only the buffer wait was involved
                     done_d = 1'b1;
                     st_d = tte_pkg::ST_IDLE;
                  end
               endcase
            end else if (fbw_exp) begin
               fatal_d = 1'b1;
               st_d = tte_pkg::ST_IDLE;
            end
         end
         tte_pkg::ST_WAIT_ACK: begin
            if (ack_valid && req_q.bcast) begin
               xt_stop = 1'b1;
               done_d = 1'b1;
               st_d = tte_pkg::ST_IDLE;
            end else if (ack_valid &&
                         ((mask_new & want_mask(req_q.members)) == want_mask(req_q.members))) begin
               mask_d = mask_new;
               xt_stop = 1'b1;
               done_d = 1'b1;
               st_d = tte_pkg::ST_IDLE;
            end else begin
               if (ack_valid) begin
                  mask_d = mask_new;
               end
               // Resend only once the transaction timer has run out
               if (xt_exp) begin
                  if (retry_q != tte_pkg::CNT_RST) begin
                     retry_d = retry_q - 4'h1;
                     att_d = 1'b1;
                     fbw_go = 1'b1;
                     st_d = tte_pkg::ST_WAIT_BUF;
                  end else begin
                     fail_d = 1'b1;
                     st_d = tte_pkg::ST_IDLE;
                  end
               end
            end
         end
         tte_pkg::ST_WAIT_RPT: begin
            if (rt_exp) begin
               if (rpt_q != tte_pkg::CNT_RST) begin
                  rpt_d = rpt_q - 4'h1;
                  att_d = 1'b1;
                  fbw_go = 1'b1;
                  st_d = tte_pkg::ST_WAIT_BUF;
               end else begin
                  rt_stop = 1'b1;
                  done_d = 1'b1;
                  st_d = tte_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            st_d = tte_pkg::ST_IDLE;
         end
      endcase
      busy_d = (st_d != tte_pkg::ST_IDLE);
   end

   // Sequencer registers
   always_ff @(posedge clock) begin
      if (!core_nrst) begin
         st_q <= tte_pkg::ST_IDLE;
         req_q <= '0;
         mask_q <= tte_pkg::MASK_RST;
         retry_q <= tte_pkg::CNT_RST;
         rpt_q <= tte_pkg::CNT_RST;
         att_q <= 1'b0;
         tx_busy <= 1'b0;
         xmit_valid <= 1'b0;
         xmit_retry <= 1'b0;
         xmit_ack_mask <= tte_pkg::MASK_RST;
         tx_done <= 1'b0;
         tx_fail <= 1'b0;
      end else begin
         st_q <= st_d;
         req_q <= req_d;
         mask_q <= mask_d;
         retry_q <= retry_d;
         rpt_q <= rpt_d;
         att_q <= att_d;
         tx_busy <= busy_d;
         xmit_valid <= xv_d;
         xmit_retry <= xr_d;
         xmit_ack_mask <= xm_d;
         tx_done <= done_d;
         tx_fail <= fail_d;
      end
   end

   // The fatal pulse sits on the outer reset so it can clear the rest
   always_ff @(posedge clock) begin
      if (!nrst) begin
         fatal_reset <= 1'b0;
      end else begin
         fatal_reset <= fatal_d;
      end
   end

   //-------------------------------------------------------------------
   // Receive transaction table
   //-------------------------------------------------------------------
   // An entry expiring this cycle no longer matches, so a late copy is
   // taken as a new transaction rather than a duplicate.
   assign live = val_q & ~rx_exp;
   assign slot = first_free(live);
   assign rx_ms = (rx_pkt.group && rx_pkt.grp_hit) ? rx_pkt.grp_ms : nongrp_rx_ms;

   always_comb begin
      for (int i = 0; i < D; i++) begin
         hit[i] = live[i] && (src_q[i] == rx_pkt.src) && (tid_q[i] == rx_pkt.tid);
      end
   end

   // Same lookup for acknowledged and repeated traffic alike
   always_comb begin
      val_d = live;
      alloc = '0;
      src_d = src_q;
      tid_d = tid_q;
      acc_d = 1'b0;
      dup_d = 1'b0;
      drop_d = 1'b0;
      rack_d = 1'b0;
      if (rx_valid) begin
         if (hit != '0) begin
            // Duplicate of a retry or repeat: re-acknowledge only if acked, do not deliver
            dup_d = 1'b1;
            rack_d = rx_pkt.acked;
         end else if (slot[tte_pkg::RXT_IW]) begin
            alloc[slot[tte_pkg::RXT_IW-1:0]] = 1'b1;
            val_d[slot[tte_pkg::RXT_IW-1:0]] = 1'b1;
            src_d[slot[tte_pkg::RXT_IW-1:0]] = rx_pkt.src;
            tid_d[slot[tte_pkg::RXT_IW-1:0]] = rx_pkt.tid;
            acc_d = 1'b1;
            rack_d = rx_pkt.acked;
         end else begin
            drop_d = 1'b1;
         end
      end
   end

   // Table registers
   always_ff @(posedge clock) begin
      if (!core_nrst) begin
         val_q <= '0;
         for (int i = 0; i < D; i++) begin
            src_q[i] <= 16'h0000;
            tid_q[i] <= 4'h0;
         end
         rx_accept <= 1'b0;
         rx_dup <= 1'b0;
         rx_drop <= 1'b0;
         rx_send_ack <= 1'b0;
      end else begin
         val_q <= val_d;
         src_q <= src_d;
         tid_q <= tid_d;
         rx_accept <= acc_d;
         rx_dup <= dup_d;
         rx_drop <= drop_d;
         rx_send_ack <= rack_d;
      end
   end

   // One receive timer per entry, started as the entry is allocated
   for (genvar g = 0; g < D; g++) begin : g_rxt
      tte_cnt u_rxt (
         .clock(clock),
         .nrst(core_nrst),
         .load(alloc[g]),
         .load_ms(rx_ms),
         .stop(1'b0),
         .tick(ms_tick),
         .running(),
         .expire(rx_exp[g])
      );
   end

endmodule // tte_engine

// ### design/tte_pkg.sv
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package tte_pkg;

   //-------------------------------------------------------------------
   // Time base
   //-------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned TICK_PERIOD_NS = 1000000;
   localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MS_PER_SEC = 1000;

   //-------------------------------------------------------------------
   // Widths and depths
   //-------------------------------------------------------------------
   localparam int unsigned TMR_W = 16;
   localparam int unsigned CNT_W = 4;
   localparam int unsigned MEMBERS = 64;
   localparam int unsigned MEM_W = 6;
   localparam int unsigned SRC_W = 16;
   localparam int unsigned TID_W = 4;
   localparam int unsigned RXT_DEPTH = 4;
   localparam int unsigned RXT_IW = 2;
   localparam int unsigned SEC_W = 17;

   //-------------------------------------------------------------------
   // Reset values
   //-------------------------------------------------------------------
   localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
   localparam logic [SEC_W-1:0] SEC_RST = 17'h00000;
   localparam logic [MEMBERS-1:0] MASK_RST = 64'h0000000000000000;

   //-------------------------------------------------------------------
   // Types
   //-------------------------------------------------------------------
   typedef enum logic [1:0] {
      SVC_UNACK = 2'h0,
      SVC_ACK = 2'h1,
      SVC_REPEAT = 2'h2
   } tte_svc_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_WAIT_BUF = 2'h1,
      ST_WAIT_ACK = 2'h3,
      ST_WAIT_RPT = 2'h2
   } tte_state_t;

   // Send request, fields from the destination address entry
   typedef struct packed {
      tte_svc_t svc;
      logic bcast;
      logic [MEM_W:0] members;
      logic [TMR_W-1:0] xact_ms;
      logic [CNT_W-1:0] retry;
      logic [TMR_W-1:0] rpt_ms;
      logic [CNT_W-1:0] rpt_cnt;
   } tte_txreq_t;

   // Arriving packet, with the group entry lookup result
   typedef struct packed {
      logic [SRC_W-1:0] src;
      logic [TID_W-1:0] tid;
      logic acked;
      logic group;
      logic grp_hit;
      logic [TMR_W-1:0] grp_ms;
   } tte_rxpkt_t;

endpackage

// ### design/tte_tick.sv
`timescale 1ns/1ps
// Millisecond and second tick prescaler
module tte_tick #(
   parameter int unsigned TICK_CYCLES = tte_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Ticks
   output logic ms_tick,
   output logic sec_tick
);

   logic [15:0] div_q, div_d;
   logic [9:0] ms_q, ms_d;
   logic ms_d_tick, sec_d_tick;

   //-------------------------------------------------------------------
   // Divider chain
   //-------------------------------------------------------------------
   always_comb begin
      div_d = div_q + 16'h0001;
      ms_d = ms_q;
      ms_d_tick = 1'b0;
      sec_d_tick = 1'b0;
      if (div_q == 16'(TICK_CYCLES - 1)) begin
         div_d = 16'h0000;
         ms_d_tick = 1'b1;
         ms_d = ms_q + 10'h001;
         if (ms_q == 10'(tte_pkg::MS_PER_SEC - 1)) begin
            ms_d = 10'h000;
            sec_d_tick = 1'b1;
         end
      end
   end

   // Registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         div_q <= 16'h0000;
         ms_q <= 10'h000;
         ms_tick <= 1'b0;
         sec_tick <= 1'b0;
      end else begin
         div_q <= div_d;
         ms_q <= ms_d;
         ms_tick <= ms_d_tick;
         sec_tick <= sec_d_tick;
      end
   end

endmodule // tte_tick

// ### design/tte_cnt.sv
`timescale 1ns/1ps
// One-shot millisecond down counter
module tte_cnt (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Control
   input wire logic load,
   input wire logic [tte_pkg::TMR_W-1:0] load_ms,
   input wire logic stop,
   input wire logic tick,
   // Status
   output logic running,
   output logic expire
);

   logic [tte_pkg::TMR_W-1:0] cnt_q, cnt_d;
   logic run_d, exp_d;

   //-------------------------------------------------------------------
   // Count down on each tick; load wins over stop and expiry
   //-------------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      run_d = running;
      exp_d = 1'b0;
      if (load) begin
         // A zero load still runs one tick so expiry is never skipped
         cnt_d = (load_ms == 16'h0000) ? 16'h0001 : load_ms;
         run_d = 1'b1;
      end else if (stop) begin
         run_d = 1'b0;
      end else if (running && tick) begin
         if (cnt_q <= 16'h0001) begin
            run_d = 1'b0;
            exp_d = 1'b1;
         end else begin
            cnt_d = cnt_q - 16'h0001;
         end
      end
   end

   // Registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cnt_q <= tte_pkg::TMR_RST;
         running <= 1'b0;
         expire <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         running <= run_d;
         expire <= exp_d;
      end
   end

endmodule // tte_cnt

// ### verif/tte_engine_monitor.sv
`timescale 1ns/1ps
// Port checker for the transport timer engine
module tte_monitor #(
   parameter int unsigned TICK_CYCLES = tte_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Send side
   input wire logic tx_req_valid,
   input wire logic tx_busy,
   input wire logic buf_free,
   input wire logic xmit_valid,
   input wire logic [tte_pkg::MEMBERS-1:0] xmit_ack_mask,
   input wire logic tx_done,
   input wire logic tx_fail,
   input wire logic fatal_reset,
   // Receive side
   input wire logic rx_valid,
   input wire tte_pkg::tte_rxpkt_t rx_pkt,
   input wire logic rx_accept,
   input wire logic rx_dup,
   input wire logic rx_drop,
   input wire logic rx_send_ack
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   // Each packet gets exactly one verdict, and only packets get one
   rx_onehot_a: assert property (rx_valid |=> $onehot({rx_accept, rx_dup, rx_drop}))
      else $error("receive verdict not unique");
   rx_cause_a: assert property (!rx_valid |=> !(rx_accept || rx_dup || rx_drop))
      else $error("receive verdict without packet");
   drop_noack_a: assert property (rx_drop |-> !rx_send_ack)
      else $error("ack for dropped packet");
   ack_follow_a: assert property (
      (rx_accept || rx_dup) |-> rx_send_ack == $past(rx_pkt.acked))
      else $error("ack does not follow service");
   // Transmission needs a held request and a free buffer the cycle before
   buf_gate_a: assert property (xmit_valid |-> $past(buf_free) && $past(tx_busy))
      else $error("send without free buffer");
   end_idle_a: assert property ((tx_done || tx_fail || fatal_reset) |-> !tx_busy)
      else $error("busy after outcome");
   fatal_pulse_a: assert property (fatal_reset |=> !fatal_reset && !tx_busy)
      else $error("fatal not self clearing");
   xmit_space_a: assert property (xmit_valid |=> !xmit_valid)
      else $error("back to back sends");
   mask_hold_a: assert property (
      !xmit_valid && !$past(fatal_reset) |-> $stable(xmit_ack_mask))
      else $error("ack mask moved");
   busy_cause_a: assert property ($rose(tx_busy) |-> $past(tx_req_valid))
      else $error("busy without request");

   cover property (tx_fail);
   cover property (rx_drop);
   cover property (fatal_reset);
endmodule // tte_monitor

bind tte_engine tte_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (
   .clock(clock), .nrst(nrst), .tx_req_valid(tx_req_valid), .tx_busy(tx_busy),
   .buf_free(buf_free), .xmit_valid(xmit_valid), .xmit_ack_mask(xmit_ack_mask),
   .tx_done(tx_done), .tx_fail(tx_fail), .fatal_reset(fatal_reset), .rx_valid(rx_valid),
   .rx_pkt(rx_pkt), .rx_accept(rx_accept), .rx_dup(rx_dup), .rx_drop(rx_drop),
   .rx_send_ack(rx_send_ack)
);

// ### verif/tte_peer.sv
`timescale 1ns/1ps
// Peer transport model: acknowledges engine transmissions
module tte_peer (
   // Clock
   input wire logic clock,
   // Scenario controls
   input wire logic [4:0] miss,
   input wire logic [1:0] lag,
   input wire logic [6:0] nmem,
   // Engine transmissions
   input wire logic xmit_valid,
   input wire logic xmit_retry,
   input wire logic [63:0] xmit_ack_mask,
   // Acknowledgements back
   output logic ack_valid,
   output logic [5:0] ack_member
);
   int seen = 0;
   logic [63:0] mask;
   initial begin
      ack_valid = 1'b0;
      ack_member = 6'h00;
   end
   // Lost acks model a lossy path; members already marked stay silent
   always begin
      @(posedge clock iff xmit_valid);
      mask = xmit_retry ? xmit_ack_mask : 64'h0000000000000000;
      seen = xmit_retry ? seen + 1 : 1;
      if (seen > miss) begin
         repeat (lag) @(posedge clock);
         for (int i = 0; i < nmem; i++) begin
            if (!mask[i]) begin
               #1;
               ack_valid = 1'b1;
               ack_member = i[5:0];
               @(posedge clock);
            end
         end
         #1;
         ack_valid = 1'b0;
         ack_member = ~ack_member; // Stale index never lingers
      end
   end
endmodule // tte_peer

// ### verif/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the transport timer engine
module tb;
   localparam int TICK = 10;
   localparam int SEC = TICK * 1000;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] fbw_n = 4'h0;
   logic [15:0] nongrp_rx_ms = 16'h0004; // Short, no sender retries here
   logic tx_req_valid = 1'b0;
   logic buf_free = 1'b1;
   logic rx_valid = 1'b0;
   tte_pkg::tte_txreq_t tx_req = '0;
   tte_pkg::tte_rxpkt_t rx_pkt = '0;
   logic tx_busy, xmit_valid, xmit_retry, tx_done, tx_fail, fatal_reset, ack_valid;
   logic rx_accept, rx_dup, rx_drop, rx_send_ack;
   logic [5:0] ack_member;
   logic [63:0] xmit_ack_mask;
   logic [63:0] exp_mask = 64'h0000000000000000;
   logic [6:0] got;
   logic [6:0] exp_q[$];
   logic [4:0] miss = 5'h00;
   logic [1:0] lag = 2'h0;
   logic [6:0] nmem = 7'h01;
   logic [3:0] cnts[4] = '{4'h0, 4'h2, 4'hF, 4'h1};
   int bad_count = 0;
   int check_count = 0;
   int xmit_n = 0;
   int gap = 0;
   int min_gap = 0;
   int cyc = 0;

   // Clock
   always #50 clock = ~clock;

   tte_engine #(.TICK_CYCLES(TICK)) i_dut (
      .clock(clock), .nrst(nrst), .fbw_n(fbw_n), .nongrp_rx_ms(nongrp_rx_ms),
      .tx_req_valid(tx_req_valid), .tx_req(tx_req), .tx_busy(tx_busy), .buf_free(buf_free),
      .xmit_valid(xmit_valid), .xmit_retry(xmit_retry), .xmit_ack_mask(xmit_ack_mask),
      .ack_valid(ack_valid), .ack_member(ack_member), .tx_done(tx_done), .tx_fail(tx_fail),
      .fatal_reset(fatal_reset), .rx_valid(rx_valid), .rx_pkt(rx_pkt), .rx_accept(rx_accept),
      .rx_dup(rx_dup), .rx_drop(rx_drop), .rx_send_ack(rx_send_ack)
   );
   tte_peer i_peer (
      .clock(clock), .miss(miss), .lag(lag), .nmem(nmem), .xmit_valid(xmit_valid),
      .xmit_retry(xmit_retry), .xmit_ack_mask(xmit_ack_mask), .ack_valid(ack_valid),
      .ack_member(ack_member)
   );

   // Compare and count
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Scoreboard on settled outputs; bounded run guards against hangs
   always @(negedge clock) begin
      cyc++;
      gap++;
      got = {fatal_reset, tx_fail, tx_done, rx_send_ack, rx_drop, rx_dup, rx_accept};
      if (nrst && got !== 7'h00) begin
         check(got, exp_q.size() > 0 ? exp_q.pop_front() : 7'h7F);
      end
      if (xmit_valid !== 1'b0) begin
         check(xmit_retry, xmit_n != 0);
         if (xmit_n != 0) begin
            check(xmit_ack_mask, exp_mask);
            check(gap >= min_gap, 1'b1);
         end
         xmit_n++;
         gap = 0;
      end
      // Ceiling on the run; a hang counts as a mismatch
      if (cyc > 70000) begin
         bad_count++;
         finish_test();
      end
   end

   // Lower strobes, then let n edges pass
   task automatic idle(input int n);
      @(posedge clock);
      #1;
      rx_valid = 1'b0;
      tx_req_valid = 1'b0;
      repeat (n) @(posedge clock);
      #1;
   endtask

   // Packet arrival; strobe stays up so calls run back to back
   task automatic rx(input logic [15:0] src, input logic [3:0] tid, input logic acked,
         input logic hit, input logic [6:0] exp);
      @(posedge clock);
      #1;
      rx_valid = 1'b1;
      rx_pkt = '{src, tid, acked, hit, hit, 16'h001E};
      exp_q.push_back(exp);
   endtask

   function automatic tte_pkg::tte_txreq_t mk(input tte_pkg::tte_svc_t svc, input logic bc,
         input logic [6:0] mem, input logic [3:0] rt, input logic [3:0] rc);
      return '{svc, bc, mem, 16'h0002, rt, 16'h0002, rc};
   endfunction

   // One send: outcome code, count of transmissions, spacing in ms, checked down to one ms less
   task automatic send(input tte_pkg::tte_txreq_t req, input logic [6:0] exp, input int nx,
         input int gap_ms);
      int t;
      xmit_n = 0;
      min_gap = (gap_ms - 1) * TICK;
      exp_q.push_back(exp);
      tx_req = req;
      tx_req_valid = 1'b1;
      idle(1);
      for (t = 0; tx_busy !== 1'b0 && t < 40000; t++) begin
         @(posedge clock);
         #1;
      end
      idle(2);
      check(xmit_n, nx);
   endtask

   // Main sequence
   initial begin
      logic [15:0] s;
      logic a;
      int t0;
      void'($urandom(32'hF9CC8D71));
      s = 16'($urandom());
      a = 1'($urandom());
      lag = 2'($urandom());
      repeat (12) @(posedge clock);
      #1;
      nrst = 1'b1;
      rx(s, 4'h1, 1'b1, 1'b1, 7'h09);
      rx(s, 4'h1, 1'b1, 1'b1, 7'h0A);
      rx(s + 16'h0001, 4'h2, 1'b0, 1'b0, 7'h01);
      rx(s + 16'h0002, 4'h3, a, 1'b0, {3'h0, a, 3'h1});
      rx(s + 16'h0003, 4'h4, 1'b0, 1'b0, 7'h01);
      rx(s + 16'h0004, 4'h5, 1'b1, 1'b0, 7'h04);
      rx(s + 16'h0001, 4'h2, 1'b0, 1'b0, 7'h02);
      idle(60);
      rx(s + 16'h0001, 4'h2, 1'b1, 1'b0, 7'h09);
      rx(s, 4'h1, 1'b0, 1'b1, 7'h02);
      idle(4);
      $display("test receive table done");
      send(mk(tte_pkg::SVC_UNACK, 1'b0, 7'h01, 4'h3, 4'h1), 7'h10, 1, 0);
      send(mk(tte_pkg::SVC_ACK, 1'b0, 7'h01, 4'h3, 4'h1), 7'h10, 1, 0);
      miss = 5'h02;
      send(mk(tte_pkg::SVC_ACK, 1'b0, 7'h01, 4'h3, 4'h1), 7'h10, 3, 2);
      miss = 5'h10;
      for (int i = 0; i < 3; i++) begin
         send(mk(tte_pkg::SVC_ACK, 1'b0, 7'h01, cnts[i], 4'h1), 7'h20, cnts[i] + 1, 2);
      end
      miss = 5'h00;
      nmem = 7'h02;
      exp_mask = 64'h0000000000000003;
      send(mk(tte_pkg::SVC_ACK, 1'b0, 7'h03, 4'h1, 4'h1), 7'h20, 2, 2);
      nmem = 7'h03;
      send(mk(tte_pkg::SVC_ACK, 1'b1, 7'h05, 4'h1, 4'h1), 7'h10, 1, 0);
      exp_mask = 64'h0000000000000000;
      nmem = 7'h00;
      for (int i = 2; i < 4; i++) begin
         send(mk(tte_pkg::SVC_REPEAT, 1'b0, 7'h01, 4'h0, cnts[i]), 7'h10, cnts[i], 2);
      end
      $display("test send services done");
      buf_free = 1'b0;
      fork
         send(mk(tte_pkg::SVC_UNACK, 1'b0, 7'h01, 4'h0, 4'h1), 7'h10, 1, 0);
         begin
            repeat (21000) @(posedge clock);
            #1;
            buf_free = 1'b1;
         end
      join
      fbw_n = 4'h1;
      buf_free = 1'b0;
      t0 = cyc;
      send(mk(tte_pkg::SVC_UNACK, 1'b0, 7'h01, 4'h0, 4'h1), 7'h40, 0, 0);
      check(cyc - t0 > 2 * SEC && cyc - t0 <= 3 * SEC + 10, 1'b1);
      $display("test buffer wait done");
      check(exp_q.size(), 0);
      finish_test();
   end
endmodule // tb
